// ==== src/bnr_rtc.sv ====
// Byte-wide static memory with a double-buffered BCD calendar clock.
// Assumes host pins are asynchronous and pass a two-stage synchroniser.
//
// What this block does, and what its host must do
// (RQ1) Keep BCD calendar, 24-hour hours
// (RQ2) Time registers sit in top eight bytes
// (RQ3) Month lengths and leap years through 2100
// (RQ4) Visible copy separate from internal counters
// (RQ5) Power fail deselects and floats data
// (RQ6) Read bit freezes visible registers
// (RQ7) Halt shows captured time, counters run
// (RQ8) Refresh all visible registers after halt
// (RQ9) Host keeps read bit low 500 us
// (RQ10) Write bit halts updates for setting
// (RQ11) Clearing write bit loads counters
// (RQ12) Seconds bit 7 stops the oscillator
// (RQ13) Test bit toggles seconds LSB 512 Hz
// (RQ14) Sustained seconds read shows the toggle
// (RQ15) Read when selected, output enabled, no write
// (RQ16) Write while select and write enable active
// (RQ17) Day bit 7 reads battery good flag
// (RQ18) Spare bits are plain storage
// (RQ19) High chip select also needed
// (RQ20) Lower locations are plain memory
// (RQ21) Seconds advance once per running second
`timescale 1ns/10ps
module bnr_rtc #(
  parameter int SEC_CYC = bnr_pkg::SEC_CYC,
  parameter int TOG_CYC = bnr_pkg::TOG_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_n_i,
  input wire logic chip_select_hi_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [bnr_pkg::AW-1:0] addr_i,
  input wire logic [bnr_pkg::DW-1:0] dq_i,
  input wire logic power_fail_trip_i,
  input wire logic battery_good_flag_i,
  output logic [bnr_pkg::DW-1:0] dq_o,
  output logic dq_oe_o
);
  import bnr_pkg::*;

  localparam logic [PRE_W-1:0] SEC_LAST = PRE_W'(SEC_CYC - 1);
  localparam logic [TOG_W-1:0] TOG_LAST = TOG_W'(TOG_CYC - 1);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // One BCD step up
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return v + 8'h01;
  endfunction

  function automatic logic [6:0] bcd_bin(input logic [7:0] v);
    return 7'(v[7:4]) * 7'd10 + 7'(v[3:0]);
  endfunction

  // Last date of the month; year 00 leaps only in a century of 4n
  function automatic logic [7:0] last_date(input logic [7:0] mon,
      input logic [7:0] yr, input logic [7:0] cen);
    logic leap;
    leap = (bcd_bin(yr) % 7'd4 == 7'd0) &&
      (yr != 8'h00 || bcd_bin(cen) % 7'd4 == 7'd0); // RQ3
    unique case (mon)
      8'h02: return leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction

  // Count one field, wrapping from last to first on carry in
  function automatic logic [7:0] step(input logic [7:0] v,
      input logic [7:0] last, input logic [7:0] first,
      input logic en, output logic wrap);
    wrap = en && (v == last);
    if (!en) begin
      return v;
    end
    return wrap ? first : bcd_inc(v);
  endfunction

  // Advance the counter set by one second
  function automatic logic [7:0][7:0] advance(input logic [7:0][7:0] c);
    logic [7:0][7:0] n;
    logic cy;
    logic unused;
    n = c;
    n[I_SEC] = step(c[I_SEC], 8'h59, 8'h00, 1'b1, cy); // RQ1
    n[I_MIN] = step(c[I_MIN], 8'h59, 8'h00, cy, cy);
    n[I_HR] = step(c[I_HR], 8'h23, 8'h00, cy, cy); // RQ1
    n[I_DAY] = step(c[I_DAY], 8'h07, RST_ONE, cy, unused);
    n[I_DATE] = step(c[I_DATE],
      last_date(c[I_MON], c[I_YR], c[I_CTL]), RST_ONE, cy, cy); // RQ3
    n[I_MON] = step(c[I_MON], 8'h12, RST_ONE, cy, cy);
    n[I_YR] = step(c[I_YR], 8'h99, 8'h00, cy, cy);
    n[I_CTL] = step(c[I_CTL], 8'h39, 8'h00, cy, unused);
    return n;
  endfunction

  // Reset image: memory clear, calendar at day one, pins idle
  function automatic bnr_state_t reset_state();
    bnr_state_t s;
    s = '0;
    s.cnt[I_DAY] = RST_ONE;
    s.cnt[I_DATE] = RST_ONE;
    s.cnt[I_MON] = RST_ONE;
    s.mem[TOP_A + 13'(I_DAY)] = RST_ONE;
    s.mem[TOP_A + 13'(I_DATE)] = RST_ONE;
    s.mem[TOP_A + 13'(I_MON)] = RST_ONE;
    s.s1.ce_n = 1'b1;
    s.s1.oe_n = 1'b1;
    s.s1.we_n = 1'b1;
    s.s1.pf = 1'b1;
    s.s2 = s.s1;
    return s;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  bnr_state_t st;
  bnr_state_t next_st;
  bnr_pins_t pins;
  logic sel;
  logic wr;
  logic rd;
  logic halt;
  logic tick;
  logic stopped;
  logic test_on;
  logic set_done;
  logic [DW-1:0] rbyte;

  assign pins = '{ce_n: ce_n_i, cs_hi: chip_select_hi_i, oe_n: oe_n_i,
    we_n: we_n_i, pf: power_fail_trip_i, bat_ok: battery_good_flag_i,
    addr: addr_i, din: dq_i};

  // Next state; host write lands last so it beats the refresh
  always_comb begin
    next_st = st;
    next_st.s1 = pins;
    next_st.s2 = st.s1;
    sel = !st.s2.ce_n && st.s2.cs_hi && !st.s2.pf; // RQ19 RQ5
    wr = sel && !st.s2.we_n; // RQ16
    rd = sel && !st.s2.oe_n && st.s2.we_n; // RQ15
    halt = st.mem[TOP_A][W_BIT] || st.mem[TOP_A][R_BIT]; // RQ6 RQ10
    stopped = st.mem[TOP_A + 13'(I_SEC)][STOP_BIT];
    test_on = st.mem[TOP_A + 13'(I_DAY)][TEST_BIT];
    set_done = st.w_prev && !st.mem[TOP_A][W_BIT];
    tick = 1'b0;
    // Time base halts with the oscillator
    if (!stopped) begin // RQ12
      if (st.pre == SEC_LAST) begin
        next_st.pre = '0;
        tick = 1'b1; // RQ21
      end else begin
        next_st.pre = st.pre + 1'b1;
      end
      if (st.tog_cnt == TOG_LAST) begin
        next_st.tog_cnt = '0;
        next_st.tog = !st.tog; // RQ13
      end else begin
        next_st.tog_cnt = st.tog_cnt + 1'b1;
      end
    end
    // Counters run regardless of host halts
    if (tick) begin
      next_st.cnt = advance(st.cnt); // RQ4 RQ7
    end
    // Loaded values replace the count; pending tick is dropped
    if (set_done) begin
      for (int i = 0; i < 8; i++) begin
        next_st.cnt[i] = st.mem[TOP_A + 13'(i)] & TIME_MASK[i]; // RQ11
      end
      next_st.pre = '0;
    end
    next_st.w_prev = st.mem[TOP_A][W_BIT];
    // Refresh all visible bytes together, spare bits untouched
    if (!halt) begin
      for (int i = 0; i < 8; i++) begin
        next_st.mem[TOP_A + 13'(i)] = // RQ8 RQ18
          (st.mem[TOP_A + 13'(i)] & ~TIME_MASK[i]) |
          (st.cnt[i] & TIME_MASK[i]);
      end
    end
    // Plain store for every address, clock bytes included
    if (wr) begin
      next_st.mem[st.s2.addr] = st.s2.din; // RQ2 RQ20
    end
    // Read path with test toggle and battery flag overlays
    rbyte = st.mem[st.s2.addr];
    if (st.s2.addr == TOP_A + 13'(I_SEC) && test_on) begin
      rbyte[0] = st.tog; // RQ14
    end
    if (st.s2.addr == TOP_A + 13'(I_DAY)) begin
      rbyte[BATT_BIT] = st.s2.bat_ok; // RQ17
    end
    next_st.dq = rd ? rbyte : '0;
    next_st.dq_oe = rd; // RQ5
  end

  // Single state register; reset image is a constant
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= reset_state();
    end else begin
      st <= next_st;
    end
  end

  assign dq_o = st.dq;
  assign dq_oe_o = st.dq_oe;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_set_clear;
    st.w_prev && !st.mem[TOP_A][W_BIT];
  endsequence

  sequence s_halted_idle;
    halt && !wr;
  endsequence

  property p_pf_quiet;
    st.s2.pf |=> !st.dq_oe;
  endproperty
  a_pf_quiet: assert property (p_pf_quiet) // RQ5
    else $error("data driven during power fail");

  property p_drive_cause;
    st.dq_oe |-> $past(rd);
  endproperty
  a_drive_cause: assert property (p_drive_cause) // RQ15
    else $error("data driven without read");

  property p_halt_freeze;
    s_halted_idle |=> $stable(st.mem[TOP_A + 13'(I_SEC)]);
  endproperty
  a_halt_freeze: assert property (p_halt_freeze) // RQ6
    else $error("visible seconds changed while halted");

  property p_refresh;
    !halt && !wr |=>
      st.mem[TOP_A + 13'(I_MIN)][6:0] == $past(st.cnt[I_MIN][6:0]);
  endproperty
  a_refresh: assert property (p_refresh) // RQ8
    else $error("visible minutes not refreshed");

  property p_keep_count;
    halt && tick && !set_done |=>
      st.cnt[I_SEC] != $past(st.cnt[I_SEC]);
  endproperty
  a_keep_count: assert property (p_keep_count) // RQ7
    else $error("counter stalled during halt");

  // A set-load while stopped legally restarts the prescaler
  property p_stopped;
    stopped && !set_done |=> $stable(st.pre) ##1
      ($stable(st.pre) || !stopped || $past(set_done));
  endproperty
  a_stopped: assert property (p_stopped) // RQ12
    else $error("time base ran with oscillator stopped");

  property p_load;
    s_set_clear |=>
      st.cnt[I_MIN] == ($past(st.mem[TOP_A + 13'(I_MIN)]) & 8'h7f);
  endproperty
  a_load: assert property (p_load) // RQ11
    else $error("set values not loaded");

  property p_bcd;
    st.cnt[I_SEC][3:0] <= 4'h9 && st.cnt[I_HR] <= 8'h23;
  endproperty
  a_bcd: assert property (p_bcd) // RQ1
    else $error("counter out of BCD range");

  property p_test_toggle;
    rd && test_on && st.s2.addr == TOP_A + 13'(I_SEC) |=>
      st.dq[0] == $past(st.tog);
  endproperty
  a_test_toggle: assert property (p_test_toggle) // RQ14
    else $error("test toggle missing on data line 0");

  property p_write_lands;
    wr |=> st.mem[$past(st.s2.addr)] == $past(st.s2.din);
  endproperty
  a_write_lands: assert property (p_write_lands) // RQ16
    else $error("host write not stored");

  property p_batt_flag;
    rd && st.s2.addr == TOP_A + 13'(I_DAY) |=>
      st.dq[BATT_BIT] == $past(st.s2.bat_ok);
  endproperty
  a_batt_flag: assert property (p_batt_flag) // RQ17
    else $error("day bit 7 does not show battery state");

  property p_deselect;
    !st.s2.cs_hi |=> !st.dq_oe;
  endproperty
  a_deselect: assert property (p_deselect) // RQ19
    else $error("data driven with high chip select low");
endmodule

// ==== src/bnr_pkg.sv ====
// Constants and carriers for the byte-wide clock/calendar memory.
// Assumes a single 50 MHz clock; all pins arrive asynchronously.
package bnr_pkg;
  // ----------------------------------------
  // Clock and time base
  // ----------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int SEC_PERIOD_MS = 1000;
  localparam int TEST_HZ = 512;
  localparam int SEC_CYC = CLK_HZ / 1000 * SEC_PERIOD_MS;
  // Half period of the test toggle, rounded down
  localparam int TOG_CYC = CLK_HZ / (2 * TEST_HZ);
  localparam int PRE_W = 26;
  localparam int TOG_W = 16;

  // ----------------------------------------
  // Memory map and field positions
  // ----------------------------------------
  localparam int AW = 13;
  localparam int DW = 8;
  localparam int WORDS = 8192;
  localparam logic [12:0] TOP_A = 13'h1ff8;
  localparam int I_CTL = 0;
  localparam int I_SEC = 1;
  localparam int I_MIN = 2;
  localparam int I_HR = 3;
  localparam int I_DAY = 4;
  localparam int I_DATE = 5;
  localparam int I_MON = 6;
  localparam int I_YR = 7;
  localparam int W_BIT = 7;
  localparam int R_BIT = 6;
  localparam int STOP_BIT = 7;
  localparam int TEST_BIT = 6;
  localparam int BATT_BIT = 7;
  // Counter bits per register, index 0 is the century byte
  localparam logic [7:0][7:0] TIME_MASK = {8'hff, 8'h1f, 8'h3f,
    8'h07, 8'h3f, 8'h7f, 8'h7f, 8'h3f};
  localparam logic [7:0] RST_ONE = 8'h01;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic ce_n;
    logic cs_hi;
    logic oe_n;
    logic we_n;
    logic pf;
    logic bat_ok;
    logic [AW-1:0] addr;
    logic [DW-1:0] din;
  } bnr_pins_t;

  typedef struct packed {
    bnr_pins_t s1;
    bnr_pins_t s2;
    logic [WORDS-1:0][DW-1:0] mem;
    logic [7:0][7:0] cnt;
    logic [PRE_W-1:0] pre;
    logic [TOG_W-1:0] tog_cnt;
    logic tog;
    logic w_prev;
    logic [DW-1:0] dq;
    logic dq_oe;
  } bnr_state_t;
endpackage

// ==== testbench/bnr_host.sv ====
// Host model: master on the byte-wide asynchronous memory bus.
// Assumes the shared 50 MHz clock; pins move just after rising edges.
`timescale 1ns/10ps
module bnr_host (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic roe_i,
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic [12:0] addr_o,
  output logic [7:0] wdata_o
);
  // ----
  // Bus cycles
  // ----
  // Idle bus at time zero; released data shows a changed pattern
  initial begin
    ce_n_o = 1'b1;
    oe_n_o = 1'b1;
    we_n_o = 1'b1;
    addr_o = 13'h0000;
    wdata_o = 8'hff;
  end

  // Deselect; address stays put so a write never ends on a moving bus
  task automatic idle();
    ce_n_o <= 1'b1;
    oe_n_o <= 1'b1;
    we_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    ce_n_o <= 1'b0;
    we_n_o <= 1'b0;
    repeat (5) @(posedge clk_i);
    wdata_o <= ~d;
    idle();
  endtask

  // Read held for n extra cycles, counting flips of data line zero
  task automatic rd(input logic [12:0] a, input int n,
                    output logic [7:0] d, output logic oe, output int fl);
    logic last;
    fl = 0;
    @(posedge clk_i);
    addr_o <= a;
    ce_n_o <= 1'b0;
    oe_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    d = rdata_i;
    oe = roe_i;
    last = rdata_i[0];
    repeat (n) begin
      @(posedge clk_i);
      #1;
      if (rdata_i[0] !== last) fl++;
      last = rdata_i[0];
    end
    @(posedge clk_i);
    idle();
  endtask
endmodule

// ==== testbench/bytewide_nv_rtc_sram_tb.sv ====
// Testbench: memory, calendar, halts, oscillator and test toggle.
// Assumes shortened second and toggle counts via design parameters.
`timescale 1ns/10ps
module bytewide_nv_rtc_sram_tb;
  import bnr_pkg::*;
  localparam int SC = 200;
  localparam int TC = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cs_hi = 1'b1;
  logic pf = 1'b0;
  logic bat = 1'b1;
  logic ce_n, oe_n, we_n, dq_oe;
  logic [12:0] addr;
  logic [7:0] wd, rdat;
  int fail_count = 0;
  int checks = 0;
  logic [7:0] setv [8] = '{8'ha0, 8'h59, 8'h59, 8'h23, 8'h01, 8'h28,
    8'h02, 8'h00};
  logic [7:0] expv [8] = '{8'h60, 8'h00, 8'h00, 8'h00, 8'h82, 8'h29,
    8'h02, 8'h00};

  // ----
  // Clock, reset, parts
  // ----
  always #10 clk = ~clk;
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
  end

  bnr_rtc #(.SEC_CYC(SC), .TOG_CYC(TC)) u_dut (.clk_i(clk),
    .rst_n_i(rst_n), .ce_n_i(ce_n), .chip_select_hi_i(cs_hi),
    .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(addr), .dq_i(wd),
    .power_fail_trip_i(pf), .battery_good_flag_i(bat), .dq_o(rdat),
    .dq_oe_o(dq_oe));

  bnr_host u_host (.clk_i(clk), .rdata_i(rdat), .roe_i(dq_oe),
    .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n), .addr_o(addr),
    .wdata_o(wd));

  // ----
  // Checking helpers
  // ----
  task automatic chk(input string w, input logic [7:0] e,
                     input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic rc(input string w, input logic [12:0] a,
                    input logic [7:0] e);
    logic [7:0] d;
    logic oe;
    int fl;
    u_host.rd(a, 0, d, oe, fl);
    chk(w, e, d);
    chk("drive", 8'h01, {7'h00, oe});
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Cut a hang well past the few thousand cycles the tests need
  initial begin
    #400000;
    fail_count++;
    close_out();
  end

  // ----
  // Tests
  // ----
  initial begin
    logic [7:0] d, d1;
    logic oe;
    int fl;
    wait (rst_n);
    rc("reset sec", TOP_A + 13'd1, 8'h00);
    rc("reset day", TOP_A + 13'd4, 8'h81);
    u_host.wr(13'h0000, 8'h5a);
    u_host.wr(13'h1ff7, 8'ha5);
    rc("low byte", 13'h0000, 8'h5a);
    rc("top byte", 13'h1ff7, 8'ha5);
    $display("test memory done");
    cs_hi <= 1'b0;
    u_host.wr(13'h0010, 8'h3c);
    u_host.rd(13'h0010, 0, d, oe, fl);
    chk("cs_hi drive", 8'h00, {7'h00, oe});
    cs_hi <= 1'b1;
    pf <= 1'b1;
    u_host.wr(13'h0011, 8'hc3);
    u_host.rd(13'h0011, 0, d, oe, fl);
    chk("pf drive", 8'h00, {7'h00, oe});
    pf <= 1'b0;
    rc("no write cs_hi", 13'h0010, 8'h00);
    rc("no write pf", 13'h0011, 8'h00);
    $display("test deselect done");
    // Day before the leap day of 2000, one second before midnight
    for (int i = 0; i < 8; i++) u_host.wr(TOP_A + 13'(i), setv[i]);
    u_host.wr(TOP_A, 8'h20);
    repeat (SC + SC / 2) @(posedge clk);
    u_host.wr(TOP_A, 8'h60);
    for (int i = 0; i < 8; i++) rc("calendar", TOP_A + 13'(i), expv[i]);
    repeat (2 * SC + SC / 2) @(posedge clk);
    rc("frozen sec", TOP_A + 13'd1, 8'h00);
    // Read bit stays low until the century test, far beyond the refresh time
    u_host.wr(TOP_A, 8'h20);
    u_host.rd(TOP_A + 13'd1, 0, d, oe, fl);
    chk("run on", 8'h01, {7'h00, d >= 8'h03 && d <= 8'h05});
    $display("test calendar done");
    u_host.wr(TOP_A + 13'd6, 8'he0);
    rc("spare bits", TOP_A + 13'd6, 8'he2);
    u_host.wr(TOP_A + 13'd1, 8'h80);
    u_host.rd(TOP_A + 13'd1, 0, d1, oe, fl);
    repeat (3 * SC) @(posedge clk);
    u_host.rd(TOP_A + 13'd1, 0, d, oe, fl);
    chk("stopped sec", d1, d);
    u_host.wr(TOP_A + 13'd1, 8'h00);
    repeat (2 * SC) @(posedge clk);
    u_host.rd(TOP_A + 13'd1, 0, d, oe, fl);
    chk("restarted", 8'h01, {7'h00, d != (d1 & 8'h7f)});
    $display("test oscillator done");
    u_host.wr(TOP_A + 13'd4, 8'h40);
    u_host.rd(TOP_A + 13'd1, 8 * TC, d, oe, fl);
    chk("toggles", 8'h01, {7'h00, fl >= 6 && fl <= 10});
    bat <= 1'b0;
    u_host.rd(TOP_A + 13'd4, 0, d, oe, fl);
    chk("day flags", 8'h40, d & 8'hc0);
    $display("test flags done");
    // Century 21, year 00: no leap day after the 28th
    setv[0] = 8'ha1;
    for (int i = 0; i < 8; i++) u_host.wr(TOP_A + 13'(i), setv[i]);
    u_host.wr(TOP_A, 8'h21);
    repeat (SC + SC / 2) @(posedge clk);
    u_host.wr(TOP_A, 8'h61);
    rc("no leap date", TOP_A + 13'd5, 8'h01);
    rc("no leap month", TOP_A + 13'd6, 8'h03);
    $display("test century done");
    close_out();
  end
endmodule
